// ==== hw/mbpwm_match_mem.sv ====
/*
  Small memory of match words with registered read data, used for shadow storage.
  Assumes single-clock synchronous use, one write and one read port.
*/
`timescale 1ns/1ps
module mbpwm_match_mem #(
  parameter int DEPTH = 7,
  parameter int WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [2:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : mbpwm_match_mem

// ==== hw/mbpwm_pkg.sv ====
/*
  Package for the match-based pulse-width timer: register offsets, field positions,
  reset values and sizes shared by the timer core, its checker and the bench.
  Assumes a simple strobe register port with 32-bit data and word offsets.
*/
package mbpwm_pkg;
  localparam int MBPWM_NUM_MATCH = 7;
  localparam int MBPWM_NUM_CAP = 4;
  localparam int MBPWM_NUM_OUT = 6;
  localparam int MBPWM_AW = 6;
  // Word offsets (byte address / 4 is not used; port is word addressed)
  localparam logic [5:0] MBPWM_OFS_IRQ_STAT = 6'h00;
  localparam logic [5:0] MBPWM_OFS_CTRL = 6'h01;
  localparam logic [5:0] MBPWM_OFS_COUNT = 6'h02;
  localparam logic [5:0] MBPWM_OFS_PRESCALE = 6'h03;
  localparam logic [5:0] MBPWM_OFS_PRE_COUNT = 6'h04;
  localparam logic [5:0] MBPWM_OFS_MATCH_CTRL = 6'h05;
  localparam logic [5:0] MBPWM_OFS_MATCH0 = 6'h06;
  localparam logic [5:0] MBPWM_OFS_CAP_CTRL = 6'h0d;
  localparam logic [5:0] MBPWM_OFS_CAP0 = 6'h0e;
  localparam logic [5:0] MBPWM_OFS_PWM_CTRL = 6'h12;
  localparam logic [5:0] MBPWM_OFS_RELEASE = 6'h13;
  localparam logic [5:0] MBPWM_OFS_IRQ_MASK = 6'h14;
  // Control register fields
  localparam int MBPWM_CTRL_RUN = 0;
  localparam int MBPWM_CTRL_RESET = 1;
  localparam int MBPWM_CTRL_PWM_EN = 3;
  // Per match: bit 3m irq, 3m+1 reset, 3m+2 stop
  localparam int MBPWM_MC_BITS = 3;
  // Per capture: bit 3c rise, 3c+1 fall, 3c+2 irq
  localparam int MBPWM_CC_BITS = 3;
  // Pulse control: bits [7:2] double-edge select for outputs 1..6, [14:9] output enables
  localparam int MBPWM_PC_SEL_LSB = 2;
  localparam int MBPWM_PC_ENA_LSB = 9;
  localparam logic [31:0] MBPWM_RESET_WORD = 32'h0000_0000;
endpackage : mbpwm_pkg

// ==== hw/mbpwm_timer.sv ====
/*
  Match-based pulse-width timer: prescaler, 32-bit count, seven match slots with
  shadowed values, four captures, six pulse outputs and a masked interrupt.
  Assumes a synchronous register port with one-cycle strobes and capture inputs
  synchronous to clk_in.
*/
// Functional notes
// - Prescaled 32-bit counter of clock cycles is the common time base
// - Seven match slots drive six single or three double edge outputs
// - Count resets on cycle-period match, setting the shared repetition rate
// - Single-edge outputs go high at cycle start unless held constant low
// - One dedicated match slot places a single-edge output's falling edge
// - Double-edge output: two slots set rise and fall, either polarity
// - Double-edge edges may sit anywhere in the cycle, any order
// - Each match may continue, stop or reset the count, plus interrupt
// - Four capture inputs latch the count on edges, optional interrupt
// - Match writes go to shadow; software must release before use
// - Period and width are any whole tick count; one shared rate
// - Without pulse mode the block is a plain match/capture timer
`timescale 1ns/1ps
module mbpwm_timer import mbpwm_pkg::*; #(
  parameter int CW = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [MBPWM_AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [MBPWM_NUM_CAP-1:0] cap_in,
  output logic [31:0] rdata_out,
  output logic [MBPWM_NUM_OUT-1:0] pwm_out,
  output logic irq_out
);
  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] pre_count;
    logic [CW-1:0] prescale;
    logic [3:0] ctrl;
    logic [20:0] match_ctrl;
    logic [11:0] cap_ctrl;
    logic [14:0] pwm_ctrl;
    logic [6:0] release_req;
    logic [10:0] irq_stat;
    logic [10:0] irq_mask;
    logic [MBPWM_NUM_MATCH-1:0][CW-1:0] match;
    logic [MBPWM_NUM_CAP-1:0][CW-1:0] cap;
    logic [MBPWM_NUM_CAP-1:0] cap_prev;
    logic [MBPWM_NUM_OUT-1:0] pwm;
    logic [2:0] load_idx;
    logic loading;
    logic [31:0] rdata;
    logic irq;
  } mbpwm_state_t;

  mbpwm_state_t cur, next_cur;
  logic [CW-1:0] shadow_q;
  logic shadow_wr;
  logic [2:0] shadow_waddr;
  logic tick;
  logic [MBPWM_NUM_MATCH-1:0] hit;
  logic [MBPWM_NUM_CAP-1:0] cap_ev;
  logic [MBPWM_NUM_OUT:0] set_b, clr_b;

  // Shadow storage; one slot read per cycle during transfer
  mbpwm_match_mem #(.DEPTH(MBPWM_NUM_MATCH), .WIDTH(CW)) u_shadow (
    .clk_in(clk_in),
    .wr_en_in(shadow_wr),
    .wr_addr_in(shadow_waddr),
    .wr_data_in(wdata_in[CW-1:0]),
    // Address the slot of the coming cycle so the registered word lines up with load_idx
    .rd_addr_in(next_cur.load_idx),
    .rd_data_out(shadow_q)
  );

  assign shadow_waddr = 3'(addr_in - MBPWM_OFS_MATCH0);
  assign shadow_wr = wr_in && addr_in >= MBPWM_OFS_MATCH0 &&
                     addr_in < MBPWM_OFS_MATCH0 + 6'(MBPWM_NUM_MATCH);
  assign tick = cur.ctrl[MBPWM_CTRL_RUN] && !cur.ctrl[MBPWM_CTRL_RESET] &&
                cur.pre_count >= cur.prescale;

  genvar g;
  generate
    for (g = 0; g < MBPWM_NUM_MATCH; g++) begin : g_match
      assign hit[g] = tick && cur.count == cur.match[g];
    end
    for (g = 0; g < MBPWM_NUM_CAP; g++) begin : g_cap
      assign cap_ev[g] = (cur.cap_ctrl[3*g] && cap_in[g] && !cur.cap_prev[g]) ||
                         (cur.cap_ctrl[3*g+1] && !cap_in[g] && cur.cap_prev[g]);
    end
    // Output n: single edge sets on slot 0, clears on slot n; double edge uses n-1 / n
    for (g = 1; g <= MBPWM_NUM_OUT; g++) begin : g_out
      assign set_b[g] = cur.pwm_ctrl[g+1] ? hit[g-1] : hit[0];
      assign clr_b[g] = hit[g];
    end
  endgenerate
  assign set_b[0] = 1'b0;
  assign clr_b[0] = 1'b0;

  always_comb begin
    next_cur = cur;
    next_cur.cap_prev = cap_in;
    next_cur.rdata = MBPWM_RESET_WORD;
    // Prescaler and count
    if (cur.ctrl[MBPWM_CTRL_RESET]) begin
      next_cur.count = '0;
      next_cur.pre_count = '0;
    end else if (cur.ctrl[MBPWM_CTRL_RUN]) begin
      if (tick) begin
        next_cur.pre_count = '0;
        next_cur.count = cur.count + 1'b1;
      end else begin
        next_cur.pre_count = cur.pre_count + 1'b1;
      end
    end
    for (int m = 0; m < MBPWM_NUM_MATCH; m++) begin
      if (hit[m]) begin
        next_cur.irq_stat[m] = cur.irq_stat[m] | cur.match_ctrl[3*m];
        if (cur.match_ctrl[3*m+1] || (m == 0 && cur.ctrl[MBPWM_CTRL_PWM_EN])) begin
          next_cur.count = '0;
        end
        if (cur.match_ctrl[3*m+2]) begin
          // Stop holds the matched value instead of stepping past it
          next_cur.count = cur.count;
          next_cur.ctrl[MBPWM_CTRL_RUN] = 1'b0;
        end
      end
    end
    // Pulse outputs only in pulse mode; clear wins when both land together
    if (cur.ctrl[MBPWM_CTRL_PWM_EN]) begin
      for (int o = 0; o < MBPWM_NUM_OUT; o++) begin
        if (!cur.pwm_ctrl[MBPWM_PC_ENA_LSB+o]) begin
          next_cur.pwm[o] = 1'b0;
        end else if (clr_b[o+1]) begin
          next_cur.pwm[o] = 1'b0;
        end else if (set_b[o+1]) begin
          next_cur.pwm[o] = 1'b1;
        end
      end
    end else begin
      next_cur.pwm = '0;
    end
    // Shadow transfer starts at the period reset in pulse mode, at once outside it; one slot per cycle
    if (cur.loading) begin
      if (cur.release_req[cur.load_idx]) begin
        next_cur.match[cur.load_idx] = shadow_q;
      end
      next_cur.release_req[cur.load_idx] = 1'b0;
      next_cur.load_idx = cur.load_idx + 3'd1;
      if (cur.load_idx == 3'(MBPWM_NUM_MATCH - 1)) begin
        next_cur.loading = 1'b0;
        next_cur.load_idx = '0;
      end
    end else if ((hit[0] || !cur.ctrl[MBPWM_CTRL_PWM_EN]) && cur.release_req != '0) begin
      next_cur.loading = 1'b1;
      next_cur.load_idx = 3'd0;
    end
    for (int c = 0; c < MBPWM_NUM_CAP; c++) begin
      if (cap_ev[c]) begin
        next_cur.cap[c] = cur.count;
      end
    end
    // Register writes; hardware set wins over a write-one clear
    if (wr_in) begin
      case (addr_in)
        MBPWM_OFS_IRQ_STAT: next_cur.irq_stat = next_cur.irq_stat & ~wdata_in[10:0];
        MBPWM_OFS_CTRL: next_cur.ctrl = wdata_in[3:0];
        MBPWM_OFS_COUNT: next_cur.count = wdata_in[CW-1:0];
        MBPWM_OFS_PRESCALE: next_cur.prescale = wdata_in[CW-1:0];
        MBPWM_OFS_PRE_COUNT: next_cur.pre_count = wdata_in[CW-1:0];
        MBPWM_OFS_MATCH_CTRL: next_cur.match_ctrl = wdata_in[20:0];
        MBPWM_OFS_CAP_CTRL: next_cur.cap_ctrl = wdata_in[11:0];
        MBPWM_OFS_PWM_CTRL: next_cur.pwm_ctrl = wdata_in[14:0];
        MBPWM_OFS_RELEASE: next_cur.release_req = cur.release_req | wdata_in[6:0];
        MBPWM_OFS_IRQ_MASK: next_cur.irq_mask = wdata_in[10:0];
        default: ;
      endcase
    end
    for (int m = 0; m < MBPWM_NUM_MATCH; m++) begin
      if (hit[m] && cur.match_ctrl[3*m]) begin
        next_cur.irq_stat[m] = 1'b1;
      end
    end
    for (int c = 0; c < MBPWM_NUM_CAP; c++) begin
      if (cap_ev[c] && cur.cap_ctrl[3*c+2]) begin
        next_cur.irq_stat[MBPWM_NUM_MATCH+c] = 1'b1;
      end
    end
    // Read mux; match offsets read the active value, not the shadow
    if (rd_in) begin
      case (addr_in)
        MBPWM_OFS_IRQ_STAT: next_cur.rdata = 32'(cur.irq_stat);
        MBPWM_OFS_CTRL: next_cur.rdata = 32'(cur.ctrl);
        MBPWM_OFS_COUNT: next_cur.rdata = 32'(cur.count);
        MBPWM_OFS_PRESCALE: next_cur.rdata = 32'(cur.prescale);
        MBPWM_OFS_PRE_COUNT: next_cur.rdata = 32'(cur.pre_count);
        MBPWM_OFS_MATCH_CTRL: next_cur.rdata = 32'(cur.match_ctrl);
        MBPWM_OFS_CAP_CTRL: next_cur.rdata = 32'(cur.cap_ctrl);
        MBPWM_OFS_PWM_CTRL: next_cur.rdata = 32'(cur.pwm_ctrl);
        MBPWM_OFS_RELEASE: next_cur.rdata = 32'(cur.release_req);
        MBPWM_OFS_IRQ_MASK: next_cur.rdata = 32'(cur.irq_mask);
        default: begin
          if (addr_in >= MBPWM_OFS_MATCH0 && addr_in < MBPWM_OFS_CAP_CTRL) begin
            next_cur.rdata = 32'(cur.match[3'(addr_in - MBPWM_OFS_MATCH0)]);
          end else if (addr_in >= MBPWM_OFS_CAP0 && addr_in < MBPWM_OFS_PWM_CTRL) begin
            next_cur.rdata = 32'(cur.cap[2'(addr_in - MBPWM_OFS_CAP0)]);
          end
        end
      endcase
    end
    next_cur.irq = |(next_cur.irq_stat & next_cur.irq_mask);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_out = cur.rdata;
  assign pwm_out = cur.pwm;
  assign irq_out = cur.irq;
endmodule : mbpwm_timer

// ==== tb/mbpwm_load.sv ====
/* Load on the pulse pins: integrates high cycles per pin.
   Assumes pin levels settle before each clk_in edge. */
`timescale 1ns/1ps
module mbpwm_load (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic [5:0] pwm_in,
  output logic [15:0] hi_out [6]
);
  // A load never answers back, so the count over whole periods is all it shows
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 6; i++) begin
      hi_out[i] <= clr_in ? 16'h0000 : hi_out[i] + 16'(pwm_in[i]);
    end
  end
endmodule : mbpwm_load

// ==== tb/mbpwm_monitor.sv ====
/* Port checker for the pulse timer.
   Assumes it is bound to mbpwm_timer and sees its ports only. */
`timescale 1ns/1ps
module mbpwm_monitor import mbpwm_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [MBPWM_AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [MBPWM_NUM_CAP-1:0] cap_in,
  input wire logic [31:0] rdata_out,
  input wire logic [MBPWM_NUM_OUT-1:0] pwm_out,
  input wire logic irq_out
);
  logic [31:0] mask_q;
  logic [31:0] cc_q;
  logic run_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  function automatic logic hit(input logic [5:0] a);
    return wr_in && addr_in == a;
  endfunction : hit
  // Shadows of written fields; hardware stops are ignored, so run_q only errs high
  always_ff @(posedge clk_in) mask_q <= rst_in ? '0 : hit(MBPWM_OFS_IRQ_MASK) ? wdata_in : mask_q;
  always_ff @(posedge clk_in) cc_q <= rst_in ? '0 : hit(MBPWM_OFS_CAP_CTRL) ? wdata_in : cc_q;
  always_ff @(posedge clk_in) run_q <= rst_in ? 1'h0 : hit(MBPWM_OFS_CTRL) ? wdata_in[0] : run_q;
  sequence s_still_reads;
    (rd_in && addr_in == MBPWM_OFS_COUNT && !run_q) ##1 (!wr_in && !run_q)
      ##1 (rd_in && addr_in == MBPWM_OFS_COUNT && !run_q);
  endsequence
  property p_pre_back;
    logic [31:0] v;
    (hit(MBPWM_OFS_PRESCALE), v = wdata_in) ##1 !wr_in
      ##1 (rd_in && addr_in == MBPWM_OFS_PRESCALE) |=> rdata_out == v;
  endproperty
  a_reset_quiet: assert property ($fell(rst_in) |-> pwm_out == '0 && !irq_out)
    else $error("outputs not idle after reset");
  a_read_idle: assert property (!rd_in |=> rdata_out == '0)
    else $error("read data without read");
  a_unmapped_zero: assert property (rd_in && addr_in > MBPWM_OFS_IRQ_MASK |=> rdata_out == '0)
    else $error("unmapped read not zero");
  a_prescale_back: assert property (p_pre_back)
    else $error("prescale read back wrong");
  a_stop_frozen: assert property (s_still_reads |=> rdata_out == $past(rdata_out, 2))
    else $error("count moved while stopped");
  a_mask_off: assert property (hit(MBPWM_OFS_IRQ_MASK) && wdata_in == '0 |-> ##2 !irq_out)
    else $error("interrupt with empty mask");
  a_out_disable: assert property (hit(MBPWM_OFS_PWM_CTRL) && wdata_in[14:9] == '0 |-> ##2 pwm_out == '0)
    else $error("disabled output driven");
  a_capture_irq: assert property ($rose(cap_in[0]) && cc_q[0] && cc_q[2] && mask_q[7] |-> ##[1:3] irq_out)
    else $error("capture interrupt missing");
endmodule : mbpwm_monitor
bind mbpwm_timer mbpwm_monitor i_mbpwm_monitor (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .cap_in, .rdata_out, .pwm_out, .irq_out);

// ==== tb/tb_top.sv ====
/* Bench for the pulse timer: register tasks, capture stimulus, pin load.
   Assumes the timer, its bound checker and the load model. */
`timescale 1ns/1ps
module tb_top import mbpwm_pkg::*; ;
  logic clk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, clr = 1'h0, irq_out;
  logic [5:0] addr_in = '0, pwm_out;
  logic [3:0] cap_in = '0;
  logic [31:0] wdata_in = '0, rdata_out, v, w0;
  logic [15:0] hi [6];
  logic [31:0] mv [6] = '{32'h0000_0009, 32'h0000_0003, 32'h0000_0002, 32'h0000_0006,
    32'h0000_0006, 32'h0000_0001};
  logic [31:0] ex [6] = '{32'h0000_0028, 32'h0000_001e, 32'h0000_0028, 32'h0000_0000,
    32'h0000_0032, 32'h0000_0000};
  int fail_count = 0, n_tests = 0;
  always #4 clk_in = ~clk_in;
  mbpwm_timer i_mbpwm_timer (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .cap_in,
    .rdata_out, .pwm_out, .irq_out);
  mbpwm_load i_mbpwm_load (.clk_in, .clr_in(clr), .pwm_in(pwm_out), .hi_out(hi));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'h1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge clk_in);
    rd_in <= 1'h1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 v = rdata_out;
  endtask : rd
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask : rdc
  task automatic poll(input logic [5:0] a, input logic [31:0] e);
    v = ~e;
    for (int i = 0; i < 40 && v !== e; i++) rd(a);
    chk(v, e);
    if (v !== e) summarize();
  endtask : poll
  task automatic wait_chk(input logic [31:0] seen_irq);
    repeat (3) @(posedge clk_in);
    #1 chk(irq_out, seen_irq);
  endtask : wait_chk
  // Whole periods only, so the count does not depend on where the window starts
  task automatic win();
    @(posedge clk_in);
    clr <= 1'h1;
    @(posedge clk_in);
    clr <= 1'h0;
    repeat (100) @(posedge clk_in);
    #1;
  endtask : win
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    rdc(6'h3f, 32'h0000_0000);
    wr(MBPWM_OFS_PRESCALE, 32'h0000_0001);
    rdc(MBPWM_OFS_PRESCALE, 32'h0000_0001);
    wr(MBPWM_OFS_CTRL, 32'h0000_0001);
    rd(MBPWM_OFS_COUNT);
    w0 = v;
    rd(MBPWM_OFS_COUNT);
    chk(v - w0, 32'h0000_0001);
    wr(MBPWM_OFS_CTRL, 32'h0000_0000);
    rd(MBPWM_OFS_COUNT);
    rdc(MBPWM_OFS_COUNT, v);
    wr(MBPWM_OFS_PRESCALE, 32'h0000_0000);
    wr(MBPWM_OFS_MATCH_CTRL, 32'h0000_0028);
    wr(MBPWM_OFS_MATCH0 + 6'h01, 32'h0000_0005);
    rdc(MBPWM_OFS_MATCH0 + 6'h01, 32'h0000_0000);
    wr(MBPWM_OFS_RELEASE, 32'h0000_0002);
    poll(MBPWM_OFS_MATCH0 + 6'h01, 32'h0000_0005);
    wr(MBPWM_OFS_CTRL, 32'h0000_0002);
    wr(MBPWM_OFS_CTRL, 32'h0000_0001);
    poll(MBPWM_OFS_COUNT, 32'h0000_0005);
    rdc(MBPWM_OFS_COUNT, 32'h0000_0005);
    chk(irq_out, 32'h0000_0000);
    wr(MBPWM_OFS_IRQ_MASK, 32'h0000_0002);
    wait_chk(32'h0000_0001);
    wr(MBPWM_OFS_IRQ_STAT, 32'h0000_07ff);
    wait_chk(32'h0000_0000);
    wr(MBPWM_OFS_CAP_CTRL, 32'h0000_0005);
    wr(MBPWM_OFS_IRQ_MASK, 32'h0000_0080);
    cap_in <= 4'h1;
    wait_chk(32'h0000_0001);
    rdc(MBPWM_OFS_CAP0, 32'h0000_0005);
    wr(MBPWM_OFS_IRQ_MASK, 32'h0000_0000);
    wr(MBPWM_OFS_MATCH_CTRL, 32'h0000_0000);
    for (int m = 0; m < 6; m++) wr(MBPWM_OFS_MATCH0 + 6'(m), mv[m]);
    wr(MBPWM_OFS_RELEASE, 32'h0000_003f);
    repeat (10) @(posedge clk_in);
    wr(MBPWM_OFS_PWM_CTRL, 32'h0000_2e50);
    wr(MBPWM_OFS_CTRL, 32'h0000_0002);
    wr(MBPWM_OFS_CTRL, 32'h0000_0009);
    win();
    win();
    for (int i = 0; i < 6; i++) chk(hi[i], ex[i]);
    wr(MBPWM_OFS_MATCH0 + 6'h01, 32'h0000_0007);
    win();
    chk(hi[0], 32'h0000_0028);
    wr(MBPWM_OFS_RELEASE, 32'h0000_0002);
    win();
    win();
    chk(hi[0], 32'h0000_0050);
    wr(MBPWM_OFS_PWM_CTRL, 32'h0000_0000);
    wait_chk(32'h0000_0000);
    chk(pwm_out, 32'h0000_0000);
    summarize();
  end
endmodule : tb_top
